// ==== rtl/nvm_wp_pkg.sv ====
// Package for the nonvolatile-memory write-protection block.
// Assumes a single 200 MHz core clock and 22-bit byte addresses.
package nvm_wp_pkg;

  localparam int ADDR_W = 22;

  // Register offsets (printed offsets are byte addresses)
  localparam logic [ADDR_W-1:0] PROGRAM_BLOCK_WRITE_LOCK_OFS  = 22'h30000A;
  localparam logic [ADDR_W-1:0] SPECIAL_REGION_WRITE_LOCK_OFS = 22'h30000B;
  localparam logic [ADDR_W-1:0] BOOT_SIZE_CONFIG_BYTE_OFS     = 22'h300006;

  // Field positions in the special-region byte
  localparam int EEPROM_LOCK_BIT = 7;
  localparam int BOOT_LOCK_BIT   = 6;
  localparam int CONFIG_LOCK_BIT = 5;
  localparam logic [7:0] SPECIAL_IMPL_MASK = 8'hE0;
  // Size field position in the boot-size byte
  localparam int BOOT_SIZE_LSB = 4;

  // Values after reset: everything unlocked (erased cells read one)
  localparam logic [7:0] PROGRAM_LOCK_RESET = 8'hFF;
  localparam logic [7:0] SPECIAL_LOCK_RESET = 8'hE0;
  localparam logic [1:0] BOOT_SIZE_RESET    = 2'h0;

  // Address map
  localparam logic [ADDR_W-1:0] CONFIG_SPACE_LO = 22'h300000;
  localparam logic [ADDR_W-1:0] CONFIG_SPACE_HI = 22'h3000FF;
  localparam int BLOCK_SHIFT = 14;
  localparam logic [ADDR_W-1:0] BOOT_HI_SMALL  = 22'h0007FF;
  localparam logic [ADDR_W-1:0] BOOT_HI_MEDIUM = 22'h000FFF;
  localparam logic [ADDR_W-1:0] BOOT_HI_LARGE  = 22'h001FFF;

  // Target memory of a self-write or erase
  typedef enum logic [1:0] {
    TARGET_PROGRAM = 2'b00,
    TARGET_EEPROM  = 2'b01,
    TARGET_CONFIG  = 2'b10
  } target_type;

  typedef struct packed {
    logic                    valid;
    target_type              target;
    logic                    erase;
    logic [ADDR_W-1:0]       addr;
    logic [7:0]              data;
  } nvm_req_type;

endpackage

// ==== rtl/nvm_lock_store.sv ====
// Lock byte store: three configuration bytes held in registers.
// Assumes writes are already qualified by the caller.
`timescale 1ns/100ps
`default_nettype none
module nvm_lock_store
  import nvm_wp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       wr_prog,
  input  wire logic       wr_spec,
  input  wire logic       wr_size,
  input  wire logic [7:0] wdata,
  output logic      [7:0] prog_lock,
  output logic      [7:0] spec_lock,
  output logic      [1:0] size_sel
);

  // Storage with power-on values
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prog_lock <= PROGRAM_LOCK_RESET;
      spec_lock <= SPECIAL_LOCK_RESET;
      size_sel  <= BOOT_SIZE_RESET;
    end
    else
    begin
      if (wr_prog)
        prog_lock <= wdata;
      if (wr_spec)
        spec_lock <= wdata & SPECIAL_IMPL_MASK;
      if (wr_size)
        size_sel <= wdata[BOOT_SIZE_LSB +: 2];
    end
  end

endmodule
`default_nettype wire

// ==== rtl/nvm_write_protect_config.sv ====
// Write-protection configuration for program, data and config memories.
// Assumes memory controllers present one request per cycle and obey the
// permit/discard answer one cycle later; prog_mode is a pin-level input.
// Assumes a plain strobe register port that never waits, through which
// the lock bytes are loaded after power-on.
// Functional notes
// - A byte of eight lock bits guards the eight program blocks, one each, bit high meaning writable.
// - A second byte holds data-EEPROM, boot-block and config-space locks in bits 7..5, lower bits reading zero.
// - A clear data-EEPROM lock refuses writes to data EEPROM.
// - A clear config lock refuses writes to the configuration address range.
// - The config lock bit only changes while the device is in external programming mode.
// - The boot-block size field sets the upper bound of the boot region and the lower bound of block 0.
// - The size field picks a boot-block top of 0007FF, 000FFF or 001FFF.
//
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module nvm_write_protect_config
  import nvm_wp_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              prog_mode,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire nvm_req_type       req,
  output nvm_req_type            grant,
  output logic                   discard,
  output logic      [7:0]        program_lock_out,
  output logic                   eeprom_write_lock,
  output logic                   boot_block_write_lock,
  output logic                   config_space_write_lock
);

  logic [7:0]        prog_lock;
  logic [7:0]        spec_lock;
  logic [1:0]        boot_block_size_sel;
  logic [2:0]        mode_sync_reg;
  logic              prog_mode_reg;
  logic [7:0]        reg_rdata_next;
  logic              allowed;
  logic [ADDR_W-1:0] boot_top;
  logic [2:0]        blk_idx;
  logic              in_boot;
  logic              in_config;
  logic              block_ok;
  logic              hit_prog;
  logic              hit_spec;
  logic              hit_size;
  logic [7:0]        spec_wdata;
  logic              sel_prog;
  logic              sel_spec;
  logic              sel_size;
  logic [7:0]        store_wdata;
  logic              eeprom_ok;
  logic              boot_ok;
  logic              config_ok;

  // Boot-block top from size field
  function automatic logic [ADDR_W-1:0] boot_top_of(input logic [1:0] sel);
    logic [ADDR_W-1:0] top;
    top = BOOT_HI_SMALL;
    if (sel == 2'h1)
      top = BOOT_HI_MEDIUM;
    else if (sel[1])
      top = BOOT_HI_LARGE;
    return top;
  endfunction

  // Programming-mode pin through three flops
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_sync_reg <= 3'h0;
    end
    else
    begin
      mode_sync_reg <= {mode_sync_reg[1:0], prog_mode};
    end
  end

  // Mode taken only once the second and third flops agree
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prog_mode_reg <= 1'b0;
    end
    else if (mode_sync_reg[2] == mode_sync_reg[1])
    begin
      prog_mode_reg <= mode_sync_reg[2];
    end
  end

  // Address match per lock byte, shared by write and read paths
  assign sel_prog = (reg_addr == PROGRAM_BLOCK_WRITE_LOCK_OFS);
  assign sel_spec = (reg_addr == SPECIAL_REGION_WRITE_LOCK_OFS);
  assign sel_size = (reg_addr == BOOT_SIZE_CONFIG_BYTE_OFS);

  // Write strobes per byte
  assign hit_prog = reg_wr && sel_prog;
  assign hit_spec = reg_wr && sel_spec;
  assign hit_size = reg_wr && sel_size;

  // Config lock keeps its value outside programming mode
  assign spec_wdata = prog_mode_reg ? reg_wdata
                    : {reg_wdata[7:6], spec_lock[CONFIG_LOCK_BIT], reg_wdata[4:0]};

  // Data into the store; only the special byte needs the mode filter
  assign store_wdata = hit_spec ? spec_wdata : reg_wdata;

  nvm_lock_store u_store (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .wr_prog   (hit_prog),
    .wr_spec   (hit_spec),
    .wr_size   (hit_size),
    .wdata     (store_wdata),
    .prog_lock (prog_lock),
    .spec_lock (spec_lock),
    .size_sel  (boot_block_size_sel)
  );

  // Read data select; unmapped addresses read zero
  always_comb
  begin
    reg_rdata_next = 8'h00;
    if (sel_prog)
      reg_rdata_next = prog_lock;
    else if (sel_spec)
      reg_rdata_next = spec_lock & SPECIAL_IMPL_MASK;
    else if (sel_size)
      reg_rdata_next = {2'h0, boot_block_size_sel, 4'h0};
  end

  // Lock bits per special region, high meaning writable
  assign eeprom_ok = spec_lock[EEPROM_LOCK_BIT];
  assign boot_ok   = spec_lock[BOOT_LOCK_BIT];
  assign config_ok = spec_lock[CONFIG_LOCK_BIT];

  // Region decode; the boot region always starts at address zero
  assign boot_top  = boot_top_of(boot_block_size_sel);
  assign blk_idx   = req.addr[BLOCK_SHIFT +: 3];
  assign in_boot   = (req.addr <= boot_top);
  assign in_config = (req.addr >= CONFIG_SPACE_LO) && (req.addr <= CONFIG_SPACE_HI);
  // Block 0 starts just above the boot block
  assign block_ok  = in_boot ? boot_ok : prog_lock[blk_idx];

  // Permission per target
  always_comb
  begin
    allowed = 1'b0;
    unique case (req.target)
      TARGET_PROGRAM: allowed = block_ok;
      TARGET_EEPROM:  allowed = eeprom_ok;
      TARGET_CONFIG:  allowed = in_config && config_ok;
      default:        allowed = 1'b0;
    endcase
  end

  // Read data: stands only in the cycle after the read strobe
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata <= 8'h00;
    end
    else
    begin
      reg_rdata <= reg_rd ? reg_rdata_next : 8'h00;
    end
  end

  // Answer to a request: copy always passed on, valid bit set only when permitted
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      grant   <= '0;
      discard <= 1'b0;
    end
    else
    begin
      grant       <= req;
      grant.valid <= req.valid && allowed;
      discard     <= req.valid && !allowed;
    end
  end

  // Block lock byte towards the program-memory controller
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      program_lock_out <= PROGRAM_LOCK_RESET;
    end
    else
    begin
      program_lock_out <= prog_lock;
    end
  end

  // Special-region locks towards the data, boot and config controllers
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      eeprom_write_lock       <= SPECIAL_LOCK_RESET[EEPROM_LOCK_BIT];
      boot_block_write_lock   <= SPECIAL_LOCK_RESET[BOOT_LOCK_BIT];
      config_space_write_lock <= SPECIAL_LOCK_RESET[CONFIG_LOCK_BIT];
    end
    else
    begin
      eeprom_write_lock       <= eeprom_ok;
      boot_block_write_lock   <= boot_ok;
      config_space_write_lock <= config_ok;
    end
  end

endmodule
`default_nettype wire

// ==== tb/nvm_mem_ctrl_model.sv ====
// Memory controller stand-in: presents one write/erase request per cycle.
// Assumes the bench hands it the next request on each rising edge.
`timescale 1ns/100ps
`default_nettype none
module nvm_mem_ctrl_model
  import nvm_wp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire nvm_req_type cmd,
  output nvm_req_type      req
);
  // Launch the queued request on the clock edge
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      req <= '0;
    else
      req <= cmd;
endmodule
`default_nettype wire

// ==== tb/nvm_write_protect_config_sva.sv ====
// Checker for the write-protection block, bound to its top module.
// Assumes one clock domain and the registered answer one cycle after a request.
`timescale 1ns/100ps
`default_nettype none
module nvm_write_protect_config_sva
  import nvm_wp_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rstn,
  input wire logic              prog_mode,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire nvm_req_type       req,
  input wire nvm_req_type       grant,
  input wire logic              discard,
  input wire logic [7:0]        program_lock_out,
  input wire logic              eeprom_write_lock,
  input wire logic              boot_block_write_lock,
  input wire logic              config_space_write_lock
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Steps of a special-byte write made in normal execution
  sequence s_normal; !prog_mode [*6]; endsequence
  sequence s_spec_wr; reg_wr && reg_addr == SPECIAL_REGION_WRITE_LOCK_OFS; endsequence
  wire cfg_in = req.addr >= CONFIG_SPACE_LO && req.addr <= CONFIG_SPACE_HI;
  wire [2:0] req_blk = req.addr[BLOCK_SHIFT +: 3];
  a_eeprom_gate: assert property (req.valid && req.target == TARGET_EEPROM |=> discard == !eeprom_write_lock)
    else $error("eeprom request answered wrongly");
  a_config_range: assert property (req.valid && req.target == TARGET_CONFIG && !cfg_in |=> discard)
    else $error("config request outside range granted");
  a_config_gate: assert property (req.valid && req.target == TARGET_CONFIG && cfg_in |=> discard == !config_space_write_lock)
    else $error("config request answered wrongly");
  a_boot_gate: assert property (req.valid && req.target == TARGET_PROGRAM && req.addr <= BOOT_HI_SMALL
    |=> discard == !boot_block_write_lock) else $error("boot request answered wrongly");
  a_block_gate: assert property (req.valid && req.target == TARGET_PROGRAM && req.addr > BOOT_HI_LARGE
    |=> discard == !program_lock_out[$past(req_blk)]) else $error("block request answered wrongly");
  a_answer_once: assert property (req.valid |=> grant.valid != discard && grant.addr == $past(req.addr))
    else $error("request not answered exactly once");
  a_idle_quiet: assert property (!req.valid |=> !grant.valid && !discard)
    else $error("answer without request");
  a_config_ro: assert property (s_normal ##0 s_spec_wr |-> ##2 $stable(config_space_write_lock))
    else $error("config lock changed in normal mode");
  a_spec_low_zero: assert property (reg_rd && reg_addr == SPECIAL_REGION_WRITE_LOCK_OFS |=> reg_rdata[4:0] == 5'h00)
    else $error("special byte low bits not zero");
endmodule
bind nvm_write_protect_config nvm_write_protect_config_sva i_sva (.sys_clk, .rstn, .prog_mode, .reg_addr, .reg_wr,
  .reg_rd, .reg_rdata, .req, .grant, .discard, .program_lock_out, .eeprom_write_lock, .boot_block_write_lock,
  .config_space_write_lock);
`default_nettype wire

// ==== tb/tb_nvm_write_protect_config.sv ====
// Testbench: random lock settings and requests against a behavioural model.
// Assumes a 200 MHz clock and the memory-controller stand-in beside the design.
`timescale 1ns/100ps
`default_nettype none
module tb_nvm_write_protect_config;
  import nvm_wp_pkg::*;
  logic              sys_clk, rstn, prog_mode, reg_wr, reg_rd, discard, e, eep_out, boot_out, cfg_out;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0]        reg_wdata, reg_rdata, prog_m, spec_m, prog_out;
  nvm_req_type       cmd, req, grant, a_s;
  int                num_errors, check_count, size_m, i;
  nvm_write_protect_config i_dut (.sys_clk, .rstn, .prog_mode, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .req, .grant, .discard, .program_lock_out(prog_out), .eeprom_write_lock(eep_out),
    .boot_block_write_lock(boot_out), .config_space_write_lock(cfg_out));
  nvm_mem_ctrl_model i_ctrl (.sys_clk, .rstn, .cmd, .req);
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(string n, logic [21:0] x, logic [21:0] g);
    check_count++;
    if (x !== g)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, x, g);
    end
  endtask
  // Register write, then mirror it in the model
  task wr(logic [21:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    if (a == PROGRAM_BLOCK_WRITE_LOCK_OFS) prog_m = d;
    if (a == BOOT_SIZE_CONFIG_BYTE_OFS) size_m = d[5:4];
    if (a == SPECIAL_REGION_WRITE_LOCK_OFS) spec_m = {d[7:6], prog_mode ? d[5] : spec_m[5], 5'h00};
  endtask
  task rd(logic [21:0] a, logic [7:0] x);
    @(posedge sys_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk("rdata", x, reg_rdata);
  endtask
  // Expected refusal of a request
  function logic ed(nvm_req_type r);
    int top;
    top = size_m == 0 ? 'h7FF : size_m == 1 ? 'hFFF : 'h1FFF;
    if (!r.valid) return 1'b0;
    if (r.target == TARGET_EEPROM) return !spec_m[7];
    if (r.target == TARGET_CONFIG) return r.addr < 'h300000 || r.addr > 'h3000FF || !spec_m[5];
    return r.addr <= top ? !spec_m[6] : !prog_m[r.addr[16:14]];
  endfunction
  // Random request, leaning on region boundaries
  function nvm_req_type rq();
    nvm_req_type r;
    int          k;
    k = $urandom_range(0, 3);
    r = '0;
    r.valid = $urandom_range(0, 3) != 0;
    r.target = target_type'($urandom_range(0, 2));
    r.erase = 1'($urandom);
    r.data = 8'($urandom);
    r.addr = 22'(k == 0 ? $urandom_range('h2FFFF0, 'h300110) :
      k == 1 ? ('h800 << $urandom_range(0, 2)) - 1 + $urandom_range(0, 1) : $urandom_range(0, 'h1FFFF));
    return r;
  endfunction
  // Compare each answer with the model one cycle later
  always @(posedge sys_clk)
  begin
    e = ed(req);
    a_s = req;
    @(negedge sys_clk);
    if (rstn)
    begin
      chk("discard", e, discard);
      chk("grant", a_s.valid & !e, grant.valid);
      chk("addr", a_s.addr, grant.addr);
      chk("fields", {a_s.target, a_s.erase, a_s.data}, {grant.target, grant.erase, grant.data});
    end
  end
  task results;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (10000) @(posedge sys_clk);
    num_errors++;
    results;
  end
  initial
  begin
    void'($urandom(7682));
    {rstn, prog_mode, reg_wr, reg_rd, reg_addr, reg_wdata, cmd} = '0;
    {prog_m, spec_m, size_m} = {8'hFF, 8'hE0, 32'h0};
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(PROGRAM_BLOCK_WRITE_LOCK_OFS, 8'hFF);
    rd(SPECIAL_REGION_WRITE_LOCK_OFS, 8'hE0);
    for (i = 0; i < 40; i++)
    begin
      wr(PROGRAM_BLOCK_WRITE_LOCK_OFS, 8'($urandom));
      wr(SPECIAL_REGION_WRITE_LOCK_OFS, 8'($urandom));
      wr(BOOT_SIZE_CONFIG_BYTE_OFS, 8'(i << 4));
      rd(SPECIAL_REGION_WRITE_LOCK_OFS, spec_m);
      rd(PROGRAM_BLOCK_WRITE_LOCK_OFS, prog_m);
      rd(22'h300020, 8'h00);
      rd(BOOT_SIZE_CONFIG_BYTE_OFS, 8'(size_m << 4));
      chk("prog_out", prog_m, prog_out);
      chk("spec_out", spec_m[7:5], {eep_out, boot_out, cfg_out});
      prog_mode <= i[0];
      repeat (50) @(posedge sys_clk) cmd <= rq();
      @(posedge sys_clk) cmd <= '0;
      repeat (3) @(posedge sys_clk);
    end
    results;
  end
endmodule
`default_nettype wire
